// *** hdl/lci_pkg.sv ***
package lci_pkg;

  // Channel count and drive timing
  localparam int NUM_CH = 2;
  localparam int SYS_CLK_HZ = 20000000;
  // Lamp period in core cycles (fixed nominal lamp clock, 50 kHz)
  localparam int LAMP_FREQ_HZ = 50000;
  localparam int LAMP_PERIOD_CYC = SYS_CLK_HZ / LAMP_FREQ_HZ;
  localparam int PER_W = 10;
  localparam logic [PER_W-1:0] HALF_PERIOD = PER_W'(LAMP_PERIOD_CYC / 2);
  // One percent of the half period, rounded down
  localparam logic [PER_W-1:0] STEP_UNIT = PER_W'(LAMP_PERIOD_CYC / 200);

  // Gate on-time limits within one half period
  localparam logic [PER_W-1:0] ON_MIN = 10'h001;
  localparam logic [PER_W-1:0] ON_MAX = 10'h0b4;
  localparam logic [PER_W-1:0] ON_RESET = 10'h010;
  // Dead time kept between the two gates of one channel
  localparam logic [PER_W-1:0] DEAD_CYC = 10'h00a;

  // Strike sequence length in lamp half periods
  localparam logic [7:0] STRIKE_HALVES = 8'h40;

  // Sense / reference comparison width
  localparam int SENSE_W = 8;
  localparam logic [SENSE_W-1:0] REF_NOMINAL = 8'h80;

  // Frequency step and overdrive configuration fields
  localparam int STEP_SEL_W = 2;
  localparam int OVD_W = 4;

  // Shutdown state machine
  typedef enum logic [1:0] {
    LCI_OFF = 2'b00,
    LCI_STRIKE = 2'b01,
    LCI_RUN = 2'b10
  } lci_state_t;

endpackage : lci_pkg

// *** hdl/lamp_control_inputs.sv ***
`timescale 1ns/100ps

module lamp_control_inputs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control pins from host logic
  input wire logic lampShutdownPin,
  input wire logic overdrivePin,
  input wire logic freqShiftPin,
  input wire logic dimmingOscPin,
  // Software configuration bits
  input wire logic shutdownEnableBit,
  input wire logic overdriveEnableBit,
  input wire logic freqShiftEnableBit,
  input wire logic freqShiftUp,
  input wire logic [lci_pkg::STEP_SEL_W-1:0] freqShiftSel,
  input wire logic [lci_pkg::OVD_W-1:0] overdriveAmount,
  input wire logic extDimClkSel,
  input wire logic [6:0] dimDuty,
  // Per-channel sense and fault inputs
  input wire logic [lci_pkg::NUM_CH*lci_pkg::SENSE_W-1:0] lampCurrentSense,
  input wire logic [lci_pkg::NUM_CH-1:0] channelFaultIn,
  // Gate drive and status outputs
  output logic [lci_pkg::NUM_CH-1:0] gateA,
  output logic [lci_pkg::NUM_CH-1:0] gateB,
  output logic dimmingPwmSignal,
  output logic faultOut,
  output logic faultOe,
  output logic powerDown
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] pinMeta_q;
  logic [3:0] pinSync_q;
  logic shutdownSyncPrev_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinMeta_q <= 4'h1;
      pinSync_q <= 4'h1;
    end else begin
      // Dimming clock shares the pin synchroniser
      // First stage feeds the second stage only
      pinMeta_q <= {dimmingOscPin, freqShiftPin, overdrivePin, lampShutdownPin};
      pinSync_q <= pinMeta_q;
    end
  end

  // Pin OR software bit; the bits already sit on this clock
  logic shutdownReq;
  logic overdriveReq;
  logic shiftReq;
  assign shutdownReq = pinSync_q[0] | shutdownEnableBit;
  assign overdriveReq = pinSync_q[1] | overdriveEnableBit;
  assign shiftReq = pinSync_q[2] | freqShiftEnableBit;

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown and strike sequencing
  lci_pkg::lci_state_t state_q;
  logic [7:0] strikeCnt_q;
  logic ctrlReset;
  logic halfTick;
  logic strikeDone;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      shutdownSyncPrev_q <= 1'b1;
    end else begin
      shutdownSyncPrev_q <= shutdownReq;
    end
  end

  // Previous value resets high, so a pin already low at reset still restarts
  // Falling edge of combined shutdown issues a controller reset
  assign ctrlReset = shutdownSyncPrev_q & ~shutdownReq;

  // Last half period of the strike sequence
  assign strikeDone = halfTick && (strikeCnt_q == lci_pkg::STRIKE_HALVES - 8'h01);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= lci_pkg::LCI_OFF;
      strikeCnt_q <= 8'h00;
    end else begin
      case (state_q)
        lci_pkg::LCI_OFF: begin
          strikeCnt_q <= 8'h00;
          if (ctrlReset) begin
            state_q <= lci_pkg::LCI_STRIKE;
          end
        end
        lci_pkg::LCI_STRIKE: begin
          if (shutdownReq) begin
            state_q <= lci_pkg::LCI_OFF;
          end else if (strikeDone) begin
            state_q <= lci_pkg::LCI_RUN;
            strikeCnt_q <= strikeCnt_q + 8'h01;
          end else if (halfTick) begin
            strikeCnt_q <= strikeCnt_q + 8'h01;
          end
        end
        lci_pkg::LCI_RUN: begin
          if (shutdownReq) begin
            state_q <= lci_pkg::LCI_OFF;
          end
        end
        default: begin
          state_q <= lci_pkg::LCI_OFF;
        end
      endcase
    end
  end

  logic lampsOn;
  // Lamps operate only while shutdown is low
  assign lampsOn = (state_q != lci_pkg::LCI_OFF) && !shutdownReq;
  // Taken from the state register so it cannot glitch
  assign powerDown = (state_q == lci_pkg::LCI_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Lamp oscillator with frequency step
  logic [lci_pkg::PER_W-1:0] halfLen;
  logic [lci_pkg::PER_W-1:0] stepAmt;
  logic [lci_pkg::PER_W-1:0] phaseCnt_q;
  logic halfSel_q;

  always_comb begin
    // Step is whole core cycles, exact only at this half period
    stepAmt = lci_pkg::PER_W'(lci_pkg::STEP_UNIT * ({8'h00, freqShiftSel} + 10'h001));
    if (!shiftReq) begin
      halfLen = lci_pkg::HALF_PERIOD;
    end else if (freqShiftUp) begin
      // Higher frequency means a shorter half period
      halfLen = lci_pkg::HALF_PERIOD - stepAmt;
    end else begin
      halfLen = lci_pkg::HALF_PERIOD + stepAmt;
    end
  end

  // Compare with >= so a step that shortens the current half still ends it
  assign halfTick = (phaseCnt_q >= halfLen - 10'h001);

  always_ff @(posedge core_clk) begin
    if (reset || ctrlReset) begin
      phaseCnt_q <= 10'h000;
      halfSel_q <= 1'b0;
    end else if (halfTick) begin
      phaseCnt_q <= 10'h000;
      halfSel_q <= ~halfSel_q;
    end else begin
      phaseCnt_q <= phaseCnt_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dimming PWM, internal or external dimming clock
  logic dimClkPrev_q;
  logic dimTick;
  logic [6:0] dimCnt_q;
  logic [13:0] intDimDiv_q;
  logic dimPwm_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dimClkPrev_q <= 1'b0;
      intDimDiv_q <= 14'h0000;
    end else begin
      dimClkPrev_q <= pinSync_q[3];
      intDimDiv_q <= intDimDiv_q + 14'h0001;
    end
  end

  logic extDimEdge;
  logic intDimTick;
  // External clock edges time the PWM when selected
  assign extDimEdge = pinSync_q[3] & ~dimClkPrev_q;
  // Free-running internal divider, one tick per wrap
  assign intDimTick = (intDimDiv_q == 14'h0000);
  assign dimTick = extDimClkSel ? extDimEdge : intDimTick;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dimCnt_q <= 7'h00;
      dimPwm_q <= 1'b0;
    end else if (dimTick) begin
      dimCnt_q <= dimCnt_q + 7'h01;
      // Full code keeps the burst on instead of one dark step
      dimPwm_q <= (dimCnt_q < dimDuty) || (dimDuty == 7'h7f);
    end
  end
  assign dimmingPwmSignal = dimPwm_q;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel regulation and push-pull drive
  logic [lci_pkg::SENSE_W-1:0] refLevel;
  logic [lci_pkg::SENSE_W-1:0] ovdStep;
  // Four sense codes per step; the largest step stays below full scale
  assign ovdStep = lci_pkg::SENSE_W'({overdriveAmount, 2'b00});

  always_comb begin
    if (overdriveReq) begin
      // Overdrive raises the reference by the configured amount
      refLevel = lci_pkg::REF_NOMINAL + ovdStep;
    end else begin
      refLevel = lci_pkg::REF_NOMINAL;
    end
  end

  logic [lci_pkg::NUM_CH-1:0] gateA_q;
  logic [lci_pkg::NUM_CH-1:0] gateB_q;

  genvar ch;
  generate
    for (ch = 0; ch < lci_pkg::NUM_CH; ch++) begin : g_ch
      logic [lci_pkg::PER_W-1:0] onTime_q;
      logic [lci_pkg::SENSE_W-1:0] sense;
      logic driveOn;
      logic inOnWindow;
      logic phaseFlip;
      assign sense = lampCurrentSense[ch*lci_pkg::SENSE_W +: lci_pkg::SENSE_W];
      assign phaseFlip = 1'(ch);


      // Channel-local sense loop
      always_ff @(posedge core_clk) begin
        if (reset || ctrlReset) begin
          onTime_q <= lci_pkg::ON_RESET;
        end else if (halfTick && dimPwm_q) begin
          // Limits keep each pulse inside its half, past the dead time
          // Low current lengthens on-time, high shortens it
          if (sense < refLevel && onTime_q < lci_pkg::ON_MAX) begin
            onTime_q <= onTime_q + 10'h001;
          end else if (sense > refLevel && onTime_q > lci_pkg::ON_MIN) begin
            onTime_q <= onTime_q - 10'h001;
          end
        end
      end

      // Dead time at the start of each half keeps the gates apart
      assign inOnWindow = (phaseCnt_q >= lci_pkg::DEAD_CYC)
        && (phaseCnt_q < lci_pkg::DEAD_CYC + onTime_q);
      assign driveOn = lampsOn && dimPwm_q && inOnWindow;

      always_ff @(posedge core_clk) begin
        if (reset || ctrlReset) begin
          gateA_q[ch] <= 1'b0;
          gateB_q[ch] <= 1'b0;
        end else begin
          // Channel 1 takes the opposite half for phasing
          gateA_q[ch] <= driveOn && ((halfSel_q ^ phaseFlip) == 1'b0);
          gateB_q[ch] <= driveOn && ((halfSel_q ^ phaseFlip) == 1'b1);
        end
      end
    end
  endgenerate

  assign gateA = gateA_q;
  assign gateB = gateB_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch, open-drain active low
  logic faultLatch_q;
  logic faultSet;
  logic faultClear;
  // Channel faults only count while the lamps are driven
  assign faultSet = |channelFaultIn && lampsOn;
  assign faultClear = shutdownReq || ctrlReset;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      faultLatch_q <= 1'b0;
    end else if (faultSet) begin
      // Set wins over a clear in the same cycle
      faultLatch_q <= 1'b1;
    end else if (faultClear) begin
      faultLatch_q <= 1'b0;
    end
  end

  // Pin data fixed low; the enable alone pulls the line
  assign faultOut = 1'b0;
  assign faultOe = faultLatch_q;

endmodule : lamp_control_inputs

// *** tb/lci_properties.sv ***
`timescale 1ns/100ps
module lci_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Watched ports
  input wire logic lampShutdownPin,
  input wire logic shutdownEnableBit,
  input wire logic [lci_pkg::NUM_CH-1:0] gateA,
  input wire logic [lci_pkg::NUM_CH-1:0] gateB,
  input wire logic dimmingPwmSignal,
  input wire logic faultOut,
  input wire logic faultOe,
  input wire logic powerDown
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////
  a_gates_apart: assert property ((gateA & gateB) == 2'h0)
    else $error("both gates on");
  a_off_dark: assert property (powerDown |-> (gateA | gateB) == 2'h0)
    else $error("gate on in power-down");
  a_pwm_gates: assert property (!dimmingPwmSignal [*2] |-> (gateA | gateB) == 2'h0)
    else $error("gate on while dimming low");
  a_fault_drain: assert property (faultOut == 1'b0)
    else $error("fault data not low");
  a_off_no_fault: assert property (powerDown [*3] |-> !faultOe)
    else $error("fault kept in power-down");
  a_pin_off: assert property (lampShutdownPin [*4] |=> powerDown)
    else $error("pin did not shut down");
  a_bit_off: assert property (shutdownEnableBit [*2] |=> powerDown)
    else $error("bit did not shut down");
  a_lamp_on: assert property ((!lampShutdownPin && !shutdownEnableBit) [*6] |-> !powerDown)
    else $error("lamps not on");
  a_wake_quiet: assert property ($fell(powerDown) |-> ((gateA | gateB) == 2'h0) [*5])
    else $error("gate on at restart");
  c_gate: cover property ($rose(gateA[0]));
  c_wake: cover property ($fell(powerDown));
  c_pwm: cover property ($rose(dimmingPwmSignal));
  c_fault: cover property ($rose(faultOe));
endmodule : lci_properties

bind lamp_control_inputs lci_properties lci_properties_i (.core_clk, .reset,
  .lampShutdownPin, .shutdownEnableBit, .gateA, .gateB, .dimmingPwmSignal,
  .faultOut, .faultOe, .powerDown);

// *** tb/lci_host_model.sv ***
`timescale 1ns/100ps
module lci_host_model (
  // Clock and control
  input wire logic core_clk,
  input wire logic run,
  // Dimming clock pin
  output logic dimmingOscPin = 1'b0
);
  logic [1:0] div_q = 2'h0;
  // Far faster than real dimming clocks, to keep bursts short
  always_ff @(posedge core_clk) begin
    if (run) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        dimmingOscPin <= !dimmingOscPin;
      end
    end
  end
endmodule : lci_host_model

// *** tb/lamp_control_inputs_tb_top.sv ***
`timescale 1ns/100ps
module lamp_control_inputs_tb_top;
  logic core_clk = 0, reset = 1, lampShutdownPin = 1, overdrivePin = 0, freqShiftPin = 0;
  logic shutdownEnableBit = 0, overdriveEnableBit = 0, freqShiftEnableBit = 0;
  logic freqShiftUp = 0, extDimClkSel = 1, oscRun = 1;
  logic [1:0] freqShiftSel = 2'h0, channelFaultIn = 2'h0, gateA, gateB;
  logic [3:0] overdriveAmount = 4'hf;
  logic [6:0] dimDuty = 7'h00;
  logic [15:0] lampCurrentSense = 16'hffff;
  logic dimmingOscPin, dimmingPwmSignal, faultOut, faultOe, powerDown;
  int err_total = 0, checked = 0;
  always #25 core_clk = !core_clk;
  lamp_control_inputs lamp_control_inputs_i (.core_clk, .reset, .lampShutdownPin,
    .overdrivePin, .freqShiftPin, .dimmingOscPin, .shutdownEnableBit, .overdriveEnableBit,
    .freqShiftEnableBit, .freqShiftUp, .freqShiftSel, .overdriveAmount, .extDimClkSel,
    .dimDuty, .lampCurrentSense, .channelFaultIn, .gateA, .gateB, .dimmingPwmSignal,
    .faultOut, .faultOe, .powerDown);
  lci_host_model lci_host_model_i (.core_clk, .run(oscRun), .dimmingOscPin);
  ////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc
  // Rise-to-rise spacing and high length of one channel's first gate
  task automatic meas(input int ch, output int per, output int wid);
    int n = 0;
    per = 0;
    while (gateA[ch] !== 1'b0 && n < 900) begin cyc(1); n++; end
    while (gateA[ch] !== 1'b1 && n < 1800) begin cyc(1); n++; end
    while (gateA[ch] === 1'b1 && per < 900) begin cyc(1); per++; end
    wid = per;
    while (gateA[ch] !== 1'b1 && per < 900) begin cyc(1); per++; end
  endtask : meas
  ////////////////////
  task automatic t_shutdown();
    cyc(20);
    chk("powerDown", 1, powerDown);
    lampShutdownPin = 0;
    cyc(6);
    chk("powerDown", 0, powerDown);
    shutdownEnableBit = 1;
    cyc(3);
    chk("powerDown", 1, powerDown);
    shutdownEnableBit = 0;
    cyc(6);
    chk("powerDown", 0, powerDown);
  endtask : t_shutdown
  // Internal divider first, then external edges; stopping the external clock
  // freezes the burst high for steady gate timing
  task automatic t_dark();
    int n = 0;
    int hi = 0;
    extDimClkSel = 0;
    dimDuty = 7'h7f;
    cyc(200);
    chk("gates", 0, {gateA, gateB});
    chk("pwm", 0, dimmingPwmSignal);
    while (dimmingPwmSignal !== 1'b1 && n < 17000) begin
      cyc(1);
      n++;
    end
    chk("pwm", 1, dimmingPwmSignal);
    extDimClkSel = 1;
    dimDuty = 7'h40;
    cyc(1100);
    for (n = 0; n < 1024; n++) begin
      hi += (dimmingPwmSignal === 1'b1);
      cyc(1);
    end
    chk("duty", 512, 16'(hi));
    dimDuty = 7'h00;
    cyc(40);
    chk("pwm", 0, dimmingPwmSignal);
    chk("gates", 0, {gateA, gateB});
    dimDuty = 7'h7f;
    n = 0;
    while (dimmingPwmSignal !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    oscRun = 0;
    chk("pwm", 1, dimmingPwmSignal);
  endtask : t_dark
  task automatic t_regulate();
    int p, w0, w1;
    lampCurrentSense = 16'hff00;
    cyc(5000);
    meas(0, p, w0);
    meas(1, p, w1);
    chk("ch0 longer", 1, w0 > w1);
    lampCurrentSense = 16'h00ff;
    cyc(5000);
    meas(0, p, w0);
    meas(1, p, w1);
    chk("ch1 longer", 1, w1 > w0);
  endtask : t_regulate
  task automatic t_overdrive(input logic viaPin);
    int p, w0, w1;
    lampCurrentSense = 16'h9090;
    cyc(5000);
    meas(0, p, w0);
    overdrivePin = viaPin;
    overdriveEnableBit = !viaPin;
    cyc(5000);
    meas(0, p, w1);
    overdrivePin = 0;
    overdriveEnableBit = 0;
    chk("overdrive", 1, w1 > w0);
  endtask : t_overdrive
  task automatic t_shift();
    int k, p, w;
    for (k = 0; k < 8; k++) begin
      freqShiftSel = 2'(k);
      freqShiftUp = k[2];
      freqShiftPin = k[0];
      freqShiftEnableBit = !k[0];
      cyc(1000);
      meas(0, p, w);
      chk("period", 16'(k[2] ? 396 - 4 * (k % 4) : 404 + 4 * (k % 4)), 16'(p));
    end
  endtask : t_shift
  task automatic t_fault();
    channelFaultIn = 2'h2;
    cyc(2);
    chk("faultOe", 1, faultOe);
    chk("faultOut", 0, faultOut);
    channelFaultIn = 2'h0;
    cyc(2);
    chk("faultOe", 1, faultOe);
    lampShutdownPin = 1;
    cyc(5);
    chk("faultOe", 0, faultOe);
    channelFaultIn = 2'h1;
    cyc(3);
    chk("faultOe", 0, faultOe);
    channelFaultIn = 2'h0;
    lampShutdownPin = 0;
    cyc(6);
    chk("powerDown", 0, powerDown);
  endtask : t_fault
  ////////////////////
  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (95000) @(posedge core_clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    cyc(1);
    reset = 0;
    t_shutdown();
    t_dark();
    t_regulate();
    t_overdrive(1);
    t_overdrive(0);
    t_shift();
    t_fault();
    report_and_stop();
  end
endmodule : lamp_control_inputs_tb_top
